/* hw/acc_pkg.sv */
package acc_pkg;
    // Sequencer timing in conversion clock periods
    localparam int unsigned SAMPLE_PERIODS = 4;
    localparam int unsigned CONVERT_PERIODS = 12;
    localparam logic [4:0] TOTAL_PERIODS = 5'h10;
    localparam int unsigned RESULT_BITS = 12;
    // Divider select codes
    localparam logic [2:0] DIV_SEL_MAX = 3'h7;
    localparam logic [6:0] DIV_CNT_RESET = 7'h00;
    // Reference select codes
    localparam logic [1:0] REF_EXT_PIN = 2'h0;
    localparam logic [1:0] REF_SUPPLY_A = 2'h1;
    localparam logic [1:0] REF_AMP_OUT = 2'h2;
    localparam logic [1:0] REF_SUPPLY_B = 2'h3;
    // Input source select codes
    localparam logic [2:0] SRC_EXT0 = 3'h0;
    localparam logic [2:0] SRC_SENSE0 = 3'h1;
    localparam logic [2:0] SRC_SENSE1 = 3'h2;
    localparam logic [2:0] SRC_GROUND = 3'h3;
    localparam logic [2:0] SRC_SUPPLY_DIV4 = 3'h4;
    localparam logic [2:0] SRC_AMP_OUT = 3'h5;
    localparam logic [2:0] SRC_EXT6 = 3'h6;
    localparam logic [2:0] SRC_EXT7 = 3'h7;
    // Reset values
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [3:0] STEP_RESET = 4'h0;
    typedef enum logic [2:0] {
        ACC_IDLE = 3'b001,
        ACC_SAMPLE = 3'b010,
        ACC_CONVERT = 3'b100
    } acc_state_t;
endpackage

/* hw/acc_adc_control.sv */
`timescale 1ns/100ps
`default_nettype none
// How it works
// - start pulse high then low begins conversion
// - busy flag set once conversion starts
// - busy flag clears at conversion end
// - completion sets interrupt flag, enabled raises interrupt
// - conversion clock is system clock divided
// - converter powered only while power enable high
// - reference chosen by reference select code
// - analog pin disables other functions and pull-high
// - analog pin overrides port direction setting
// - external sources route channel 0-7, else floating
// - internal source codes pick internal signals
// - 4 sample plus 12 convert periods
// - format bit selects result byte split
module acc_adc_control #(
    parameter int unsigned NUM_PINS = 8
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic start_bit,
    input wire logic adc_power_enable,
    input wire logic [2:0] adc_clock_divider_select,
    input wire logic [1:0] reference_select,
    input wire logic [2:0] input_source_select,
    input wire logic [3:0] external_channel_select,
    input wire logic result_format_select,
    input wire logic int_enable,
    input wire logic int_flag_clear,
    input wire logic comparator_in,
    input wire logic [NUM_PINS-1:0] pin_analog_enable,
    input wire logic [NUM_PINS-1:0] pin_pull_high_cfg,
    input wire logic [NUM_PINS-1:0] pin_output_enable_cfg,
    output logic conv_busy_flag,
    output logic adc_int_flag,
    output logic adc_int,
    output logic adc_powered,
    output logic adc_clock,
    output logic sample_hold,
    output logic ref_ext_pin_sel,
    output logic ref_supply_sel,
    output logic ref_amp_sel,
    output logic [NUM_PINS-1:0] pin_channel_connect,
    output logic src_sense0_sel,
    output logic src_sense1_sel,
    output logic src_ground_sel,
    output logic src_supply_div4_sel,
    output logic src_amp_sel,
    output logic [11:0] dac_trial,
    output logic [7:0] result_high_byte,
    output logic [7:0] result_low_byte,
    output logic [NUM_PINS-1:0] pin_digital_enable,
    output logic [NUM_PINS-1:0] pin_pull_high_en,
    output logic [NUM_PINS-1:0] pin_output_enable
);

    acc_pkg::acc_state_t state_q;
    logic start_prev_q;
    logic [6:0] div_cnt_q;
    logic tick;
    logic [3:0] step_q;
    logic [11:0] sar_q;
    logic [11:0] sar_d;
    logic [11:0] result_q;
    logic done;
    logic start_seen;

    // Terminal count of the divider for a select code
    function automatic logic [6:0] div_limit(input logic [2:0] sel);
        logic [7:0] full;
        full = 8'h01 << sel;
        div_limit = 7'(full - 8'h01);
    endfunction

    // Length of the high half of a conversion clock period
    function automatic logic [6:0] div_half(input logic [2:0] sel);
        logic [7:0] full;
        full = 8'h01 << sel;
        div_half = 7'(full >> 1);
    endfunction

    // Start fires on the falling edge of the start bit, so a held-high bit starts nothing until it drops
    assign start_seen = start_prev_q && !start_bit;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            start_prev_q <= 1'b0;
        end else if (clk_en) begin
            start_prev_q <= start_bit;
        end
    end

    // Divider free-runs only while powered and busy; powered off it sits at zero
    always_ff @(posedge core_clk) begin
        if (!reset_n || (clk_en && !adc_power_enable)) begin
            div_cnt_q <= acc_pkg::DIV_CNT_RESET;
            adc_clock <= 1'b0;
        end else if (clk_en) begin
            if (state_q == acc_pkg::ACC_IDLE || div_cnt_q >= div_limit(adc_clock_divider_select)) begin
                div_cnt_q <= acc_pkg::DIV_CNT_RESET;
            end else begin
                div_cnt_q <= div_cnt_q + 7'h01;
            end
            // High for the first half of each period; divide-by-1 has no half, so it stays low
            adc_clock <= (state_q != acc_pkg::ACC_IDLE) && (div_cnt_q < div_half(adc_clock_divider_select));
        end
    end

    assign tick = (state_q != acc_pkg::ACC_IDLE) && (div_cnt_q >= div_limit(adc_clock_divider_select));
    assign done = (state_q == acc_pkg::ACC_CONVERT) && tick && (step_q == 4'(acc_pkg::CONVERT_PERIODS - 1));

    // Next trial word; dac_trial is loaded with it as well, so the comparator
    // judges the new trial in the very next cycle even when the divider is bypassed
    always_comb begin
        sar_d = sar_q;
        if (state_q == acc_pkg::ACC_IDLE) begin
            if (start_seen) begin
                sar_d = 12'h800;
            end
        end else if (state_q == acc_pkg::ACC_CONVERT && tick) begin
            // Keep the trial bit if the comparator says input is above it
            if (!comparator_in) begin
                sar_d[4'(11) - step_q] = 1'b0;
            end
            if (step_q != 4'(acc_pkg::CONVERT_PERIODS - 1)) begin
                sar_d[4'(10) - step_q] = 1'b1;
            end
        end
    end

    // Sequencer: sample periods then one bit decision per period
    always_ff @(posedge core_clk) begin
        if (!reset_n || (clk_en && !adc_power_enable)) begin
            state_q <= acc_pkg::ACC_IDLE;
            step_q <= acc_pkg::STEP_RESET;
            sar_q <= acc_pkg::RESULT_RESET;
            dac_trial <= acc_pkg::RESULT_RESET;
        end else if (clk_en) begin
            sar_q <= sar_d;
            dac_trial <= sar_d;
            case (state_q)
                acc_pkg::ACC_IDLE: begin
                    // Starts while busy never reach here, so they are dropped
                    if (start_seen) begin
                        state_q <= acc_pkg::ACC_SAMPLE;
                        step_q <= acc_pkg::STEP_RESET;
                    end
                end
                acc_pkg::ACC_SAMPLE: begin
                    if (tick) begin
                        if (step_q == 4'(acc_pkg::SAMPLE_PERIODS - 1)) begin
                            state_q <= acc_pkg::ACC_CONVERT;
                            step_q <= acc_pkg::STEP_RESET;
                        end else begin
                            step_q <= step_q + 4'h1;
                        end
                    end
                end
                acc_pkg::ACC_CONVERT: begin
                    if (tick) begin
                        if (step_q != 4'(acc_pkg::CONVERT_PERIODS - 1)) begin
                            step_q <= step_q + 4'h1;
                        end else begin
                            state_q <= acc_pkg::ACC_IDLE;
                            step_q <= acc_pkg::STEP_RESET;
                        end
                    end
                end
                default: begin
                    state_q <= acc_pkg::ACC_IDLE;
                end
            endcase
        end
    end

    // Busy follows the sequencer; it drops in the same edge the result lands
    always_ff @(posedge core_clk) begin
        if (!reset_n || (clk_en && !adc_power_enable)) begin
            conv_busy_flag <= 1'b0;
        end else if (clk_en) begin
            if (state_q == acc_pkg::ACC_IDLE && start_seen) begin
                conv_busy_flag <= 1'b1;
            end else if (done) begin
                conv_busy_flag <= 1'b0;
            end
        end
    end

    // Result capture; kept across power-down so software can still read it
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            result_q <= acc_pkg::RESULT_RESET;
        end else if (clk_en && done) begin
            result_q <= comparator_in ? sar_q : {sar_q[11:1], 1'b0};
        end
    end

    // Result byte split per format bit
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            result_high_byte <= 8'h00;
            result_low_byte <= 8'h00;
        end else if (clk_en) begin
            if (!result_format_select) begin
                result_high_byte <= result_q[11:4];
                result_low_byte <= {4'h0, result_q[3:0]};
            end else begin
                result_high_byte <= {4'h0, result_q[11:8]};
                result_low_byte <= result_q[7:0];
            end
        end
    end

    // Interrupt flag; a completion in the clear cycle wins over the clear
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            adc_int_flag <= 1'b0;
            adc_int <= 1'b0;
        end else if (clk_en) begin
            if (done) begin
                adc_int_flag <= 1'b1;
            end else if (int_flag_clear) begin
                adc_int_flag <= 1'b0;
            end
            adc_int <= int_enable && (done || (adc_int_flag && !int_flag_clear));
        end
    end

    // Power indication and sample/hold switch
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            adc_powered <= 1'b0;
            sample_hold <= 1'b0;
        end else if (clk_en) begin
            adc_powered <= adc_power_enable;
            // Lags the sequencer by one cycle; conv_busy_flag and dac_trial switch on the same edge as the sequencer
            sample_hold <= (state_q == acc_pkg::ACC_SAMPLE);
        end
    end

    // Reference switches; codes 01 and 11 both land on the supply
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ref_ext_pin_sel <= 1'b0;
            ref_supply_sel <= 1'b0;
            ref_amp_sel <= 1'b0;
        end else if (clk_en) begin
            ref_ext_pin_sel <= (reference_select == acc_pkg::REF_EXT_PIN);
            ref_supply_sel <= (reference_select == acc_pkg::REF_SUPPLY_A)
                || (reference_select == acc_pkg::REF_SUPPLY_B);
            ref_amp_sel <= (reference_select == acc_pkg::REF_AMP_OUT);
        end
    end

    // External pin routing
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pin_channel_connect <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                // Codes 8 and up address no pin, so the input floats
                pin_channel_connect[i] <= ((input_source_select == acc_pkg::SRC_EXT0)
                    || (input_source_select == acc_pkg::SRC_EXT6)
                    || (input_source_select == acc_pkg::SRC_EXT7))
                    && (external_channel_select == 4'(i));
            end
        end
    end

    // Internal source switches; pin routing connects only for the external codes 0, 6 and 7,
    // so no pin joins them whatever the channel code
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            src_sense0_sel <= 1'b0;
            src_sense1_sel <= 1'b0;
            src_ground_sel <= 1'b0;
            src_supply_div4_sel <= 1'b0;
            src_amp_sel <= 1'b0;
        end else if (clk_en) begin
            src_sense0_sel <= (input_source_select == acc_pkg::SRC_SENSE0);
            src_sense1_sel <= (input_source_select == acc_pkg::SRC_SENSE1);
            src_ground_sel <= (input_source_select == acc_pkg::SRC_GROUND);
            src_supply_div4_sel <= (input_source_select == acc_pkg::SRC_SUPPLY_DIV4);
            src_amp_sel <= (input_source_select == acc_pkg::SRC_AMP_OUT);
        end
    end

    // Pin overrides: an analog pin loses digital function, pull-high and output drive
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pin_digital_enable <= '1;
            pin_pull_high_en <= '0;
            pin_output_enable <= '0;
        end else if (clk_en) begin
            pin_digital_enable <= ~pin_analog_enable;
            pin_pull_high_en <= pin_pull_high_cfg & ~pin_analog_enable;
            pin_output_enable <= pin_output_enable_cfg & ~pin_analog_enable;
        end
    end

endmodule
`default_nettype wire

/* tb/acc_adc_control_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module acc_adc_control_asserts #(
    parameter int unsigned NUM_PINS = 8
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic start_bit,
    input wire logic adc_power_enable,
    input wire logic [2:0] adc_clock_divider_select,
    input wire logic [1:0] reference_select,
    input wire logic [2:0] input_source_select,
    input wire logic [3:0] external_channel_select,
    input wire logic int_enable,
    input wire logic [NUM_PINS-1:0] pin_analog_enable,
    input wire logic conv_busy_flag,
    input wire logic adc_int_flag,
    input wire logic adc_int,
    input wire logic adc_powered,
    input wire logic adc_clock,
    input wire logic sample_hold,
    input wire logic ref_supply_sel,
    input wire logic ref_amp_sel,
    input wire logic [NUM_PINS-1:0] pin_channel_connect,
    input wire logic [NUM_PINS-1:0] pin_digital_enable,
    input wire logic [NUM_PINS-1:0] pin_pull_high_en
);
    logic [11:0] busy_cnt_q;
    logic ext_src;
    logic [NUM_PINS-1:0] exp_chan;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Length of the current busy stretch, so one check covers every divider code
    always_ff @(posedge core_clk) begin
        busy_cnt_q <= (!reset_n || !conv_busy_flag) ? 12'h000 : busy_cnt_q + 12'h001;
    end
    // Expected routing; channel codes 8 and up leave the input floating
    assign ext_src = input_source_select == 3'h0 || input_source_select[2:1] == 2'h3;
    assign exp_chan = (ext_src && !external_channel_select[3]) ? NUM_PINS'(1) << external_channel_select[2:0] : '0;
    property p_start;
        !start_bit && $past(start_bit) && !conv_busy_flag && adc_powered && adc_power_enable |=> conv_busy_flag;
    endproperty
    a_start: assert property (p_start) else $error("busy not raised after start");
    property p_done;
        $fell(conv_busy_flag) && adc_power_enable && adc_powered |-> adc_int_flag;
    endproperty
    a_done: assert property (p_done) else $error("done without request flag");
    property p_irq;
        $rose(adc_int_flag) && int_enable |=> adc_int;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled interrupt missing");
    property p_len;
        $fell(conv_busy_flag) && adc_power_enable |-> busy_cnt_q - (12'h010 << adc_clock_divider_select) <= 12'h002;
    endproperty
    a_len: assert property (p_len) else $error("conversion length wrong");
    property p_off;
        !adc_power_enable [*2] |-> !conv_busy_flag && !adc_powered;
    endproperty
    a_off: assert property (p_off) else $error("busy while powered down");
    property p_ref;
        $past(reset_n) && $stable(reference_select)
            |-> ref_amp_sel == (reference_select == 2'h2) && ref_supply_sel == reference_select[0];
    endproperty
    a_ref: assert property (p_ref) else $error("reference decode wrong");
    property p_route;
        $past(reset_n) && $stable(input_source_select) && $stable(external_channel_select)
            |-> pin_channel_connect == exp_chan;
    endproperty
    a_route: assert property (p_route) else $error("channel routing wrong");
    property p_pins;
        $past(reset_n) && $stable(pin_analog_enable) |-> (pin_analog_enable & (pin_pull_high_en | pin_digital_enable)) == '0;
    endproperty
    a_pins: assert property (p_pins) else $error("analog pin keeps digital use");
    // Divided codes must show a running conversion clock right after the start
    property p_clk;
        $rose(conv_busy_flag) && adc_power_enable && adc_clock_divider_select != 3'h0 |-> ##[1:2] adc_clock;
    endproperty
    a_clk: assert property (p_clk) else $error("conversion clock not running");
    property p_hold;
        $rose(conv_busy_flag) && adc_power_enable |=> sample_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("sampling phase missing");
endmodule
bind acc_adc_control acc_adc_control_asserts #(.NUM_PINS(NUM_PINS)) u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .start_bit(start_bit), .adc_power_enable(adc_power_enable),
    .adc_clock_divider_select(adc_clock_divider_select), .reference_select(reference_select),
    .input_source_select(input_source_select), .external_channel_select(external_channel_select),
    .int_enable(int_enable), .pin_analog_enable(pin_analog_enable), .conv_busy_flag(conv_busy_flag),
    .adc_int_flag(adc_int_flag), .adc_int(adc_int), .adc_powered(adc_powered), .adc_clock(adc_clock),
    .sample_hold(sample_hold), .ref_supply_sel(ref_supply_sel), .ref_amp_sel(ref_amp_sel),
    .pin_channel_connect(pin_channel_connect), .pin_digital_enable(pin_digital_enable),
    .pin_pull_high_en(pin_pull_high_en)
);
`default_nettype wire

/* tb/acc_analog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module acc_analog_model (
    input wire logic [11:0] dac_trial,
    input wire logic [11:0] level,
    output logic comparator_in
);
    // Ideal comparator with no offset, so a full search returns the level exactly
    assign comparator_in = level >= dac_trial;
endmodule
`default_nettype wire

/* tb/tb_adc_conversion_control.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_adc_conversion_control;
    logic core_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, start_bit = 1'b0, adc_power_enable = 1'b1, ext;
    logic result_format_select = 1'b0, int_enable = 1'b0, int_flag_clear = 1'b0, comparator_in;
    logic [2:0] adc_clock_divider_select = 3'h0, input_source_select = 3'h0;
    logic [1:0] reference_select = 2'h0;
    logic [3:0] external_channel_select = 4'h0;
    logic [11:0] level = 12'h000, dac_trial;
    logic [7:0] pin_analog_enable = 8'h00, pin_pull_high_cfg = 8'hff, pin_output_enable_cfg = 8'hff;
    logic conv_busy_flag, adc_int_flag, adc_int, adc_powered, adc_clock, sample_hold;
    logic ref_ext_pin_sel, ref_supply_sel, ref_amp_sel, src_sense0_sel, src_sense1_sel;
    logic src_ground_sel, src_supply_div4_sel, src_amp_sel;
    logic [7:0] pin_channel_connect, result_high_byte, result_low_byte;
    logic [7:0] pin_digital_enable, pin_pull_high_en, pin_output_enable;
    int fail_count = 0;
    int cmp_count = 0;
    acc_adc_control dut (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .start_bit(start_bit),
        .adc_power_enable(adc_power_enable), .adc_clock_divider_select(adc_clock_divider_select),
        .reference_select(reference_select), .input_source_select(input_source_select),
        .external_channel_select(external_channel_select), .result_format_select(result_format_select),
        .int_enable(int_enable), .int_flag_clear(int_flag_clear), .comparator_in(comparator_in),
        .pin_analog_enable(pin_analog_enable), .pin_pull_high_cfg(pin_pull_high_cfg),
        .pin_output_enable_cfg(pin_output_enable_cfg), .conv_busy_flag(conv_busy_flag),
        .adc_int_flag(adc_int_flag), .adc_int(adc_int), .adc_powered(adc_powered), .adc_clock(adc_clock),
        .sample_hold(sample_hold), .ref_ext_pin_sel(ref_ext_pin_sel), .ref_supply_sel(ref_supply_sel),
        .ref_amp_sel(ref_amp_sel), .pin_channel_connect(pin_channel_connect),
        .src_sense0_sel(src_sense0_sel), .src_sense1_sel(src_sense1_sel), .src_ground_sel(src_ground_sel),
        .src_supply_div4_sel(src_supply_div4_sel), .src_amp_sel(src_amp_sel), .dac_trial(dac_trial),
        .result_high_byte(result_high_byte), .result_low_byte(result_low_byte),
        .pin_digital_enable(pin_digital_enable), .pin_pull_high_en(pin_pull_high_en),
        .pin_output_enable(pin_output_enable)
    );
    acc_analog_model u_analog (.dac_trial(dac_trial), .level(level), .comparator_in(comparator_in));
    always #20 core_clk = ~core_clk;
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Bounded poll; a stuck flag shows up as a mismatch rather than a hang
    task automatic wait_busy(input logic v);
        int n = 0;
        while (conv_busy_flag !== v && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(conv_busy_flag, v)
    endtask
    task automatic pulse_start();
        start_bit = 1'b1;
        @(negedge core_clk);
        start_bit = 1'b0;
    endtask
    // A second start while busy must not stretch or restart the conversion
    task automatic conv(input logic [2:0] s, input logic [11:0] v, input logic f);
        adc_clock_divider_select = s;
        level = v;
        result_format_select = f;
        int_enable = s[0];
        pulse_start();
        wait_busy(1'b1);
        pulse_start();
        wait_busy(1'b0);
        repeat (3) @(negedge core_clk);
        `CHK(result_high_byte, f ? {4'h0, v[11:8]} : v[11:4])
        `CHK(result_low_byte, f ? v[7:0] : {4'h0, v[3:0]})
        `CHK(adc_int_flag, 1'b1)
        `CHK(adc_int, s[0])
        int_flag_clear = 1'b1;
        @(negedge core_clk);
        int_flag_clear = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK(adc_int_flag, 1'b0)
        `CHK(conv_busy_flag, 1'b0)
    endtask
    initial begin
        repeat (5) @(negedge core_clk);
        `CHK(pin_digital_enable, 8'hff)
        reset_n = 1'b1;
        repeat (4) @(negedge core_clk);
        // Codes under 4 give a period below the recommended floor at this clock; the ideal
        // comparator settles at once, so only accuracy on real silicon would suffer
        for (int i = 0; i < 8; i++) begin
            conv(3'(i), i == 1 ? 12'h000 : i == 7 ? 12'hfff : 12'h5a5 ^ {4{3'(i)}}, i[0]);
        end
        $display("conversion tests done");
        pulse_start();
        wait_busy(1'b1);
        adc_power_enable = 1'b0;
        repeat (3) @(negedge core_clk);
        `CHK(conv_busy_flag, 1'b0)
        `CHK({adc_powered, adc_clock}, 2'h0)
        pulse_start();
        repeat (2) @(negedge core_clk);
        `CHK(conv_busy_flag, 1'b0)
        adc_power_enable = 1'b1;
        repeat (4) @(negedge core_clk);
        `CHK(adc_powered, 1'b1)
        pin_analog_enable = 8'h0f;
        repeat (2) @(negedge core_clk);
        `CHK({pin_pull_high_en, pin_digital_enable}, 16'hf0f0)
        `CHK(pin_output_enable, 8'hf0)
        $display("power and pin tests done");
        // The reference pin is never set up as an input here, so internal references stay apart
        for (int r = 0; r < 4; r++) begin
            reference_select = 2'(r);
            repeat (2) @(negedge core_clk);
            `CHK({ref_ext_pin_sel, ref_supply_sel, ref_amp_sel}, r == 0 ? 3'h4 : r == 2 ? 3'h1 : 3'h2)
        end
        // Internal sources only ever see an absent channel, so pins never join them
        for (int s = 0; s < 8; s++) begin
            for (int e = 0; e < 16; e++) begin
                ext = s == 0 || s > 5;
                if (ext || e > 7) begin
                    input_source_select = 3'(s);
                    external_channel_select = 4'(e);
                    repeat (2) @(negedge core_clk);
                    `CHK(pin_channel_connect, (ext && e < 8) ? 8'h01 << e : 8'h00)
                    `CHK({src_amp_sel, src_supply_div4_sel, src_ground_sel, src_sense1_sel, src_sense0_sel},
                        ext ? 5'h00 : 5'h01 << (s - 1))
                end
            end
        end
        $display("routing tests done");
        test_done();
    end
    // All tests take about 4400 cycles; the limit leaves ample slack
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
